// >>> logic/dac_cmd_pkg.sv
package dac_cmd_pkg;

  localparam int          NUM_CH         = 8;
  localparam int          CODE_W         = 12;

  // target address forms
  localparam logic [3:0]  ADDR_PREFIX    = 4'h9;
  localparam logic [7:0]  BCAST_WR_BYTE  = 8'h8e;

  // command field codes
  localparam logic [3:0]  CMD_WR_LATCH   = 4'h0;
  localparam logic [3:0]  CMD_UPD_SEL    = 4'h1;
  localparam logic [3:0]  CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0]  CMD_WR_UPD     = 4'h3;
  localparam logic [3:0]  CMD_POWER      = 4'h4;
  localparam logic [3:0]  CMD_CLEAR      = 4'h5;
  localparam logic [3:0]  CMD_LOAD_MASK  = 4'h6;
  localparam logic [3:0]  CMD_SOFT_RST   = 4'h7;
  localparam logic [3:0]  CMD_REF_STATIC = 4'h8;
  localparam logic [3:0]  CMD_REF_FLEX   = 4'h9;
  localparam logic [3:0]  ACC_ALL        = 4'hf;

  // field positions in the 16-bit data word
  localparam int          VAL_LSB        = 4;
  localparam int          PD_MODE_LSB    = 13;
  localparam int          PD_MASK_MSB    = 12;
  localparam int          CLR_LSB        = 4;
  localparam int          LMASK_LSB      = 8;
  localparam int          RST_KIND_LSB   = 14;
  localparam int          REF_STATIC_BIT = 4;
  localparam int          REF_FLEX_LSB   = 12;

  // values after reset
  localparam logic [11:0] LATCH_RST      = 12'h000;
  localparam logic [1:0]  PD_MODE_RST    = 2'h0;
  localparam logic [1:0]  CLEAR_RST      = 2'h0;
  localparam logic [7:0]  LMASK_RST      = 8'h00;
  localparam logic        REF_STATIC_RST = 1'b0;
  localparam logic [2:0]  REF_FLEX_RST   = 3'h0;
  localparam logic [6:0]  SYNC_RST       = 7'h7f;

  // encodings
  localparam logic [1:0]  PD_ON          = 2'h0;
  localparam logic [1:0]  CLR_ZERO       = 2'h0;
  localparam logic [1:0]  CLR_MID        = 2'h1;
  localparam logic [1:0]  CLR_FULL       = 2'h2;
  localparam logic [11:0] CODE_ZERO      = 12'h000;
  localparam logic [11:0] CODE_MID       = 12'h800;
  localparam logic [11:0] CODE_FULL      = 12'hfff;
  localparam logic [1:0]  RST_POR        = 2'h0;
  localparam logic [1:0]  RST_HS_SET     = 2'h1;
  localparam logic [1:0]  RST_HS_KEEP    = 2'h2;
  localparam logic [2:0]  FLEX_FOLLOW    = 3'h4;
  localparam logic [2:0]  FLEX_ON        = 3'h5;
  localparam logic [2:0]  FLEX_OFF       = 3'h6;

  function automatic logic [7:0] chan_select(input logic [3:0] acc);
    logic [7:0] sel;
    sel = 8'h00;
    if (acc == ACC_ALL) begin
      sel = 8'hff;
    end else if (!acc[3]) begin
      sel[acc[2:0]] = 1'b1;
    end
    return sel;
  endfunction

endpackage

// >>> logic/chan_bank_if.sv
interface chan_bank_if;
  import dac_cmd_pkg::*;
  logic [7:0]  wr_en;
  logic [7:0]  upd_en;
  logic [11:0] wr_val;
  logic        clr_all;
  logic        hold_clear;
  logic [11:0] clear_val;
  logic [11:0] latch [NUM_CH];
  logic [11:0] dac   [NUM_CH];

  modport ctl (output wr_en, upd_en, wr_val, clr_all, hold_clear, clear_val,
               input  latch, dac);
  modport mem (input  wr_en, upd_en, wr_val, clr_all, hold_clear, clear_val,
               output latch, dac);
endinterface

// >>> logic/chan_bank.sv
module chan_bank
  import dac_cmd_pkg::*;
(
  input wire logic  core_clk,
  input wire logic  rst_sync_b,
  chan_bank_if.mem  bus
);

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        bus.latch[ch] <= LATCH_RST;
      end else if (bus.clr_all) begin
        bus.latch[ch] <= LATCH_RST;
      end else if (bus.wr_en[ch]) begin
        bus.latch[ch] <= bus.wr_val;
      end
    end

    // a same-cycle write and update passes the new value straight through
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        bus.dac[ch] <= LATCH_RST;
      end else if (bus.clr_all) begin
        bus.dac[ch] <= LATCH_RST;
      end else if (bus.hold_clear) begin
        bus.dac[ch] <= bus.clear_val;
      end else if (bus.upd_en[ch]) begin
        bus.dac[ch] <= bus.wr_en[ch] ? bus.wr_val : bus.latch[ch];
      end
    end
  end

endmodule

// >>> logic/dac_write_decoder.sv
module dac_write_decoder
  import dac_cmd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        scl_pin,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [2:0]  addr_pins,
  input  wire logic        load_strobe_pin,
  input  wire logic        clear_pin_b,
  output logic [95:0]      dac_code,
  output logic [15:0]      pd_mode,
  output logic             ref_on,
  output logic [1:0]       clear_target,
  output logic             hs_mode
);
  import dac_cmd_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CA, ST_UPPER_DATA_BYTE, ST_LOWER_DATA_BYTE, ST_SKIP} link_st_e;
  logic             rst_meta_ff, rst_sync_b;
  logic [6:0]       sync1_ff, sync2_ff;
  logic [2:0]       prev_ff;
  link_st_e         st_ff;
  logic [3:0]       bit_cnt_ff;
  logic             in_ack_ff, pend_ff, exec_ff, sda_oe_ff, sda_out_ff;
  logic [7:0]       shift_ff, ca_ff, upper_data_byte_ff, lower_data_byte_ff, lmask_ff;
  logic [1:0]       pd_ff [NUM_CH];
  logic [1:0]       clear_ff;
  logic             ref_static_ff, hs_ff, ref_on_ff, nxt_ref_on;
  logic [2:0]       ref_flex_ff;
  logic             scl_s, sda_s, load_s, clear_s;
  logic [2:0]       addr_s;
  logic             scl_rise, scl_fall, start_c, stop_c, load_fall;
  logic             byte_done, ack_fall, addr_hit, ack_now;
  logic [15:0]      data_w;
  logic [3:0]       cmd;
  logic [7:0]       sel, chan_on;
  logic             soft_rst;

  chan_bank_if bank_bus ();

  chan_bank u_bank (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .bus        (bank_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_b  <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_b  <= rst_meta_ff;
    end
  end

  // idle bus lines read high, so reset to ones avoids a false start
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      prev_ff  <= SYNC_RST[2:0];
    end else begin
      sync1_ff <= {addr_pins, clear_pin_b, load_strobe_pin, sda_in, scl_pin};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[2:0];
    end
  end

  assign scl_s     = sync2_ff[0];
  assign sda_s     = sync2_ff[1];
  assign load_s    = sync2_ff[2];
  assign clear_s   = sync2_ff[3];
  assign addr_s    = sync2_ff[6:4];
  assign scl_rise  = scl_s & ~prev_ff[0];
  assign scl_fall  = ~scl_s & prev_ff[0];
  assign start_c   = scl_s & prev_ff[0] & ~sda_s & prev_ff[1];
  assign stop_c    = scl_s & prev_ff[0] & sda_s & ~prev_ff[1];
  assign load_fall = ~load_s & prev_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  assign byte_done = scl_fall && !in_ack_ff && bit_cnt_ff == 4'h8 && st_ff != ST_IDLE;
  assign ack_fall  = scl_fall && in_ack_ff;
  // reads to the own address are not served here, so they get no ack
  assign addr_hit  = (shift_ff == {ADDR_PREFIX, addr_s, 1'b0})
                  || (shift_ff == BCAST_WR_BYTE);

  always_comb begin
    case (st_ff)
      ST_ADDR:                  ack_now = addr_hit;
      ST_CA, ST_UPPER_DATA_BYTE, ST_LOWER_DATA_BYTE:  ack_now = 1'b1;
      default:                  ack_now = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_ff      <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      in_ack_ff  <= 1'b0;
    end else if (start_c) begin
      st_ff      <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      in_ack_ff  <= 1'b0;
    end else if (stop_c) begin
      st_ff      <= ST_IDLE;
      in_ack_ff  <= 1'b0;
    end else if (byte_done) begin
      in_ack_ff  <= 1'b1;
      bit_cnt_ff <= 4'h0;
      case (st_ff)
        ST_ADDR: st_ff <= addr_hit ? ST_CA : ST_SKIP;
        ST_CA:   st_ff <= ST_UPPER_DATA_BYTE;
        ST_UPPER_DATA_BYTE: st_ff <= ST_LOWER_DATA_BYTE;
        ST_LOWER_DATA_BYTE: st_ff <= ST_UPPER_DATA_BYTE;
        default: st_ff <= st_ff;
      endcase
    end else if (ack_fall) begin
      in_ack_ff <= 1'b0;
    end else if (scl_rise && !in_ack_ff && st_ff != ST_IDLE) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      shift_ff <= 8'h00;
    end else if (scl_rise && !in_ack_ff) begin
      shift_ff <= {shift_ff[6:0], sda_s};
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ca_ff   <= 8'h00;
      upper_data_byte_ff <= 8'h00;
      lower_data_byte_ff <= 8'h00;
    end else if (byte_done) begin
      case (st_ff)
        ST_CA:   ca_ff   <= shift_ff;
        ST_UPPER_DATA_BYTE: upper_data_byte_ff <= shift_ff;
        ST_LOWER_DATA_BYTE: lower_data_byte_ff <= shift_ff;
        default: ca_ff   <= ca_ff;
      endcase
    end
  end

  // ack drive changes only while scl is low, never faking a start or stop
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sda_oe_ff  <= 1'b0;
      sda_out_ff <= 1'b0;
    end else if (start_c || stop_c || ack_fall) begin
      sda_oe_ff  <= 1'b0;
      sda_out_ff <= 1'b0;
    end else if (byte_done) begin
      sda_oe_ff  <= ack_now;
      sda_out_ff <= 1'b0;
    end
  end

  // a stop before the last ack ends drops the pending command
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pend_ff <= 1'b0;
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= ack_fall && pend_ff;
      if (start_c || stop_c || ack_fall) begin
        pend_ff <= 1'b0;
      end else if (byte_done && st_ff == ST_LOWER_DATA_BYTE) begin
        pend_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution

  assign data_w   = {upper_data_byte_ff, lower_data_byte_ff};
  assign cmd      = ca_ff[7:4];
  assign sel      = chan_select(ca_ff[3:0]);
  assign soft_rst = exec_ff && cmd == CMD_SOFT_RST
                 && data_w[RST_KIND_LSB +: 2] != 2'h3;

  always_comb begin
    bank_bus.wr_en      = 8'h00;
    bank_bus.upd_en     = 8'h00;
    bank_bus.wr_val     = data_w[VAL_LSB +: CODE_W];
    bank_bus.clr_all    = soft_rst;
    bank_bus.hold_clear = !clear_s && clear_ff != 2'h3;
    case (clear_ff)
      CLR_ZERO: bank_bus.clear_val = CODE_ZERO;
      CLR_MID:  bank_bus.clear_val = CODE_MID;
      CLR_FULL: bank_bus.clear_val = CODE_FULL;
      default:  bank_bus.clear_val = CODE_ZERO;
    endcase
    if (exec_ff) begin
      case (cmd)
        CMD_WR_LATCH: bank_bus.wr_en = sel;
        CMD_UPD_SEL:  bank_bus.upd_en = sel;
        CMD_WR_UPD: begin
          bank_bus.wr_en  = sel;
          bank_bus.upd_en = sel;
        end
        CMD_WR_UPD_ALL: begin
          bank_bus.wr_en  = sel;
          bank_bus.upd_en = (sel != 8'h00) ? 8'hff : 8'h00;
        end
        default: bank_bus.wr_en = 8'h00;
      endcase
    end
    if (load_fall) begin
      bank_bus.upd_en = bank_bus.upd_en | ~lmask_ff;
    end
  end

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_pd
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        pd_ff[ch] <= PD_MODE_RST;
      end else if (soft_rst) begin
        pd_ff[ch] <= PD_MODE_RST;
      end else if (exec_ff && cmd == CMD_POWER && data_w[PD_MASK_MSB - ch]) begin
        pd_ff[ch] <= data_w[PD_MODE_LSB +: 2];
      end
    end
    assign chan_on[ch] = (pd_ff[ch] == PD_ON);
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clear_ff      <= CLEAR_RST;
      lmask_ff      <= LMASK_RST;
      ref_static_ff <= REF_STATIC_RST;
      ref_flex_ff   <= REF_FLEX_RST;
    end else if (soft_rst) begin
      clear_ff      <= CLEAR_RST;
      lmask_ff      <= LMASK_RST;
      ref_static_ff <= REF_STATIC_RST;
      ref_flex_ff   <= REF_FLEX_RST;
    end else if (exec_ff) begin
      case (cmd)
        CMD_CLEAR:      clear_ff      <= data_w[CLR_LSB +: 2];
        CMD_LOAD_MASK:  lmask_ff      <= data_w[LMASK_LSB +: 8];
        CMD_REF_STATIC: ref_static_ff <= data_w[REF_STATIC_BIT];
        CMD_REF_FLEX:   ref_flex_ff   <= data_w[REF_FLEX_LSB +: 3];
        default:        clear_ff      <= clear_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hs_ff <= 1'b0;
    end else if (exec_ff && cmd == CMD_SOFT_RST && !data_w[RST_KIND_LSB + 1]) begin
      hs_ff <= data_w[RST_KIND_LSB];
    end
  end

  // 111 is not a listed code; the reference is held off for it
  always_comb begin
    if (!ref_flex_ff[2]) begin
      nxt_ref_on = ref_static_ff && (|chan_on);
    end else begin
      case (ref_flex_ff)
        FLEX_FOLLOW: nxt_ref_on = |chan_on;
        FLEX_ON:     nxt_ref_on = 1'b1;
        FLEX_OFF:    nxt_ref_on = 1'b0;
        default:     nxt_ref_on = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ref_on_ff <= 1'b0;
    end else begin
      ref_on_ff <= nxt_ref_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sda_out      = sda_out_ff;
  assign sda_oe       = sda_oe_ff;
  assign ref_on       = ref_on_ff;
  assign clear_target = clear_ff;
  assign hs_mode      = hs_ff;
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_out
    assign dac_code[ch*CODE_W +: CODE_W] = bank_bus.dac[ch];
    assign pd_mode[ch*2 +: 2]            = pd_ff[ch];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);
  bcast_ack_a: assert property (
    (byte_done && st_ff == ST_ADDR && shift_ff == BCAST_WR_BYTE) |=> sda_oe_ff[*1] ##1 1)
    else $error("broadcast write address not acknowledged");
  latch_write_a: assert property (
    (exec_ff && cmd == CMD_WR_LATCH && !ca_ff[3] && !soft_rst)
      |=> bank_bus.latch[ca_ff[2:0]] == $past(data_w[15:4]))
    else $error("latch write lost");
  bad_access_a: assert property (
    (exec_ff && cmd <= CMD_WR_UPD && ca_ff[3] && ca_ff[3:0] != ACC_ALL)
      |-> bank_bus.wr_en == 8'h00)
    else $error("invalid access code wrote a latch");
  bcast_latch_a: assert property (
    (exec_ff && cmd == CMD_WR_LATCH && ca_ff[3:0] == ACC_ALL)
      |=> bank_bus.latch[0] == $past(data_w[15:4]) && bank_bus.latch[7] == $past(data_w[15:4]))
    else $error("broadcast latch write incomplete");
  sel_update_a: assert property (
    (exec_ff && cmd == CMD_UPD_SEL && !ca_ff[3] && clear_s)
      |=> bank_bus.dac[ca_ff[2:0]] == $past(bank_bus.latch[ca_ff[2:0]]))
    else $error("select update did not copy latch");
  wr_update_a: assert property (
    (exec_ff && cmd == CMD_WR_UPD && !ca_ff[3] && clear_s)
      |=> bank_bus.dac[ca_ff[2:0]] == $past(data_w[15:4]))
    else $error("write and update missed the DAC register");
  exec_edge_a: assert property (exec_ff |-> $past(ack_fall) && $past(pend_ff))
    else $error("command ran outside the last ack falling edge");
  soft_por_a: assert property (
    (exec_ff && cmd == CMD_SOFT_RST && data_w[15:14] == RST_POR)
      |=> !hs_ff && lmask_ff == LMASK_RST && bank_bus.latch[0] == LATCH_RST)
    else $error("soft reset left state behind");
  ref_forced_a: assert property ((ref_flex_ff == FLEX_ON) [*2] |-> ref_on_ff)
    else $error("forced-on reference is off");
  ref_off_a: assert property ((ref_flex_ff == FLEX_OFF) [*2] |-> !ref_on_ff)
    else $error("forced-off reference is on");
  load_pin_a: assert property (
    (load_fall && !lmask_ff[0] && !exec_ff && clear_s)
      |=> bank_bus.dac[0] == $past(bank_bus.latch[0]))
    else $error("load pin did not update unmasked channel");
  exec_cover_c: cover property (exec_ff && cmd == CMD_WR_UPD);
  bcast_cover_c: cover property (byte_done && st_ff == ST_ADDR && shift_ff == BCAST_WR_BYTE);
  pair_cover_c: cover property (exec_ff ##[1:400] exec_ff);
  load_cover_c: cover property (load_fall && lmask_ff != 8'h00);

endmodule

// >>> bench/i2c_ctl_model.sv
module i2c_ctl_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // four core clocks per half bit give the 800 ns bus clock
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // sda released before scl rises, so this also works as a repeated start
  task automatic start_c();
    tick(1);
    sda_low <= 1'b0;
    tick(2);
    scl     <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl     <= 1'b0;
    tick(2);
  endtask

  // scl is left high: the bus clock stands still between frames
  task automatic stop_c();
    sda_low <= 1'b1;
    tick(2);
    scl     <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // msb first, then the ninth clock with sda released for the target
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      tick(2);
      scl     <= 1'b1;
      tick(4);
      scl     <= 1'b0;
      tick(2);
    end
    sda_low <= 1'b0;
    tick(2);
    scl     <= 1'b1;
    tick(2);
    ack = !sda_line;
    tick(2);
    scl     <= 1'b0;
    tick(2);
  endtask
endmodule

// >>> bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dac_cmd_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst_b;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic [2:0]  addr_pins;
  logic        load_pin;
  logic        clear_b;
  logic [95:0] dac_code;
  logic [15:0] pd_mode;
  logic        ref_on;
  logic [1:0]  clear_target;
  logic        hs_mode;
  logic [15:0] lfsr = 16'h005a;
  logic [7:0]  own;
  int          miscompares = 0;
  int          check_count = 0;
  int          lat[8];
  int          dac[8];
  int          pd[8];
  int          clr, lm, rs, rf, hs;

  // pull-up: released line reads high
  wire sda_line = !(sda_low || (sda_oe && !sda_out));

  always #50 core_clk = ~core_clk;

  dac_write_decoder DUT (
    .core_clk(core_clk), .rst_b(rst_b), .scl_pin(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(addr_pins),
    .load_strobe_pin(load_pin), .clear_pin_b(clear_b), .dac_code(dac_code),
    .pd_mode(pd_mode), .ref_on(ref_on), .clear_target(clear_target), .hs_mode(hs_mode)
  );

  i2c_ctl_model ctl (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic check_all();
    logic [95:0] ed;
    logic [15:0] ep;
    logic [11:0] cv;
    logic        any_on;
    logic        eref;
    cv = (clr == 0) ? CODE_ZERO : (clr == 1) ? CODE_MID : CODE_FULL;
    any_on = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ed[12*i+:12] = (!clear_b && clr != 3) ? cv : 12'(dac[i]);
      ep[2*i+:2]   = 2'(pd[i]);
      any_on       = any_on | (pd[i] == 0);
    end
    eref = rf[2] ? ((rf == 4) ? any_on : (rf == 5)) : (rs == 1 && any_on);
    chk("dac_code", dac_code, ed);
    chk("pd_mode", 96'(pd_mode), 96'(ep));
    chk("config", 96'({ref_on, clear_target, hs_mode}), 96'({eref, 2'(clr), hs[0]}));
  endtask

  task automatic exec(input logic [3:0] c, input logic [3:0] a, input logic [15:0] w);
    logic [7:0] sel;
    sel = (a == ACC_ALL) ? 8'hff : a[3] ? 8'h00 : 8'(1 << a[2:0]);
    for (int i = 0; i < 8; i++) begin
      case (c)
        4'h0: if (sel[i]) lat[i] = w[15:4];
        4'h1: if (sel[i]) dac[i] = lat[i];
        4'h2: begin
          if (sel[i]) lat[i] = w[15:4];
        end
        4'h3: if (sel[i]) begin
          lat[i] = w[15:4];
          dac[i] = lat[i];
        end
        4'h4: if (w[12-i]) pd[i] = w[14:13];
        4'h7: if (w[15:14] != 2'h3) begin
          lat[i] = 0;
          dac[i] = 0;
          pd[i]  = 0;
        end
        default: ;
      endcase
    end
    if (c == 4'h2 && sel != 8'h00) dac = lat;
    if (c == 4'h5) clr = w[5:4];
    if (c == 4'h6) lm = w[15:8];
    if (c == 4'h8) rs = w[4];
    if (c == 4'h9) rf = w[14:12];
    if (c == 4'h7 && w[15:14] != 2'h3) begin
      hs  = (w[15:14] == 2'h1) ? 1 : (w[15:14] == 2'h2) ? hs : 0;
      clr = 0;
      lm  = 0;
      rs  = 0;
      rf  = 0;
    end
  endtask

  // later pairs reuse the retained command byte with fresh random data
  task automatic frame(input logic [7:0] ab, input logic [7:0] ca, input logic [15:0] w0,
                       input int pairs, input logic exp_ack = 1'b1);
    logic [15:0] w;
    logic        a;
    w = w0;
    ctl.start_c();
    ctl.send(ab, a);
    chk("addr_ack", 96'(a), 96'(exp_ack));
    if (exp_ack) begin
      ctl.send(ca, a);
      for (int p = 0; p < pairs; p++) begin
        ctl.send(w[15:8], a);
        ctl.send(w[7:0], a);
        exec(ca[7:4], ca[3:0], w);
        repeat (8) @(posedge core_clk);
        check_all();
        w = rnd();
      end
    end
    ctl.stop_c();
    repeat (4) @(posedge core_clk);
    check_all();
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    logic [15:0] w;
    logic [1:0]  kinds[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    rst_b     = 1'b0;
    addr_pins = 3'h0;
    load_pin  = 1'b1;
    clear_b   = 1'b1;
    clr = 0; lm = 0; rs = 0; rf = 0; hs = 0;
    for (int i = 0; i < 8; i++) begin
      lat[i] = 0; dac[i] = 0; pd[i] = 0;
    end
    repeat (8) @(posedge core_clk);
    w = rnd();
    rst_b     <= 1'b1;
    addr_pins <= w[2:0];
    own = {4'h9, w[2:0], 1'b0};
    repeat (4) @(posedge core_clk);
    check_all();
    for (int i = 0; i < 8; i++) frame(own, {CMD_WR_LATCH, 4'(i)}, rnd(), 2);
    frame(own, {CMD_UPD_SEL, 4'h3}, 16'h0000, 1);
    frame(own, {CMD_UPD_SEL, 4'h9}, 16'h0000, 1);
    frame(own, {CMD_WR_LATCH, 4'hc}, rnd(), 1);
    frame(own, {CMD_WR_UPD_ALL, 4'ha}, rnd(), 1);
    frame(own, {CMD_UPD_SEL, ACC_ALL}, 16'h0000, 1);
    frame(BCAST_WR_BYTE, {CMD_WR_LATCH, ACC_ALL}, rnd(), 1);
    frame(own, {CMD_WR_UPD, 4'h6}, rnd(), 2);
    frame(own, {CMD_WR_UPD, ACC_ALL}, rnd(), 1);
    frame(own, {CMD_WR_LATCH, 4'h1}, rnd(), 1);
    frame(own, {CMD_WR_UPD_ALL, 4'h2}, rnd(), 1);
    frame(own, {CMD_WR_UPD_ALL, ACC_ALL}, rnd(), 1);
    frame(own ^ 8'h0e, {CMD_WR_LATCH, ACC_ALL}, rnd(), 1, 1'b0);
    frame(own | 8'h01, {CMD_WR_LATCH, ACC_ALL}, rnd(), 1, 1'b0);
    frame(BCAST_WR_BYTE | 8'h01, {CMD_WR_LATCH, ACC_ALL}, rnd(), 1, 1'b0);
    $display("test data paths done");
    for (int i = 0; i < 4; i++) frame(own, {CMD_POWER, 4'h0}, (rnd() & 16'h1fe0) | 16'(i << 13), 1);
    for (int k = 0; k < 2; k++) begin
      frame(own, {CMD_POWER, 4'h0}, (k == 1) ? 16'h3fe0 : 16'h1fe0, 1);
      for (int j = 0; j < 16; j++) begin
        frame(own, {CMD_REF_STATIC, 4'h0}, 16'(j[3]) << 4, 1);
        frame(own, {CMD_REF_FLEX, 4'h0}, 16'(j[2:0]) << 12, 1);
      end
    end
    $display("test power and reference done");
    for (int i = 0; i < 4; i++) begin
      frame(own, {CMD_CLEAR, 4'h0}, 16'(i << 4) | (rnd() & 16'hffcf), 1);
      clear_b <= 1'b0;
      // for codes 0 to 2 the pin loads the clear code into the DAC registers, which keep it afterwards
      for (int k = 0; k < 8; k++) begin
        if (i != 3) dac[k] = (i == 0) ? CODE_ZERO : (i == 1) ? CODE_MID : CODE_FULL;
      end
      repeat (6) @(posedge core_clk);
      check_all();
      clear_b <= 1'b1;
      repeat (6) @(posedge core_clk);
      check_all();
    end
    $display("test clear done");
    frame(own, {CMD_LOAD_MASK, 4'h0}, 16'h5a00, 1);
    frame(own, {CMD_WR_LATCH, ACC_ALL}, rnd(), 1);
    load_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < 8; i++) if (!lm[i]) dac[i] = lat[i];
    check_all();
    load_pin <= 1'b1;
    for (int c = 10; c < 16; c++) frame(own, {4'(c), 4'h0}, rnd(), 1);
    $display("test load pin and unknown commands done");
    foreach (kinds[k]) begin
      frame(own, {CMD_WR_UPD, ACC_ALL}, rnd(), 1);
      frame(own, {CMD_SOFT_RST, 4'h0}, {kinds[k], 14'h1234}, 1);
    end
    $display("test soft reset done");
    summarize();
  end
endmodule
